/* File: verilog/iobc_controller.sv */
// Purpose: Turns processor accesses into simple, module or PC-bus style I/O cycles.
// Assumes: Processor request port synchronous to clk_sys_in; pins sampled on it.
// Notes: The 8MHz and 16MHz bases are enable pulses divided from clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
`include "iobc_cfg.svh"

// Functional notes
// - The I/O bus is 16 bits wide and some accesses may reach 32 bits via external transceivers.
// - Three cycle kinds exist: simple at 8MHz, module of variable length at 8MHz, PC style at 16MHz.
// - Simple cycles are 16-bit only with four speeds chosen by the address.
// - Simple and module writes drive the upper data half, reads return on the lower half.
// - A simple cycle asserts its chip select with the matching read or write strobe on 8MHz timing.
// - Module cycles are 16-bit and their length is set by an active-low request and grant handshake.
// - A module cycle asserts chip select and the direction signal but keeps both strobes inactive.
// - PC style cycles pass the lower half directly and control external latches for the upper half.
// - Five PC style address areas each drive their own chip select with the same access style.
// - PC style cycles use one of four fixed 16MHz types, the largest area allowing only two.
// - External logic can stretch a PC style cycle by dropping ready, and the cycle waits for it.
// - A PC style access asserts the area's chip select plus the strobe matching the direction.
// - Two special inputs let external logic multiplex a full 32-bit read over the 16-bit bus.
// - On a read using the latching input, upper data comes from the I/O bus, not the latches.
module iobc_controller
#(
  parameter int FAST_DIV = `IOBC_FAST_DIV
)
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [`IOBC_ADDR_W-1:0] req_addr_in,
  input wire logic [31:0] req_wdata_in,
  output logic req_ready_out,
  output logic req_done_out,
  output logic [31:0] req_rdata_out,
  output logic [15:0] io_addr_out,
  output logic [15:0] io_data_out,
  output logic io_data_oe_out,
  input wire logic [15:0] io_data_in,
  output logic io_read_strobe_n_out,
  output logic io_write_strobe_n_out,
  output logic io_read_not_write_out,
  output logic simple_cs_n_out,
  output logic module_cs_n_out,
  output logic [`IOBC_PC_AREAS-1:0] pc_cs_n_out,
  output logic module_request_n_out,
  input wire logic module_grant_n_in,
  input wire logic ready_in,
  output logic slow_io_clock_out,
  output logic ext_latch_out,
  output logic ext_dir_read_out,
  input wire logic [15:0] ext_hi_data_in,
  input wire logic mux32_select_in,
  input wire logic mux32_latch_in
);
  import iobc_pkg::*;

  // ****************************************************************
  // Timing bases
  // ****************************************************************
  function automatic logic [3:0] strobe_len(input iobc_kind_t kind, input logic [1:0] sel);
    logic [3:0] len;
    len = `IOBC_SIMPLE_LEN0;
    if (kind == IOBC_KIND_PC)
    begin
      unique case (sel)
        2'h0: len = `IOBC_PC_LEN0;
        2'h1: len = `IOBC_PC_LEN1;
        2'h2: len = `IOBC_PC_LEN2;
        2'h3: len = `IOBC_PC_LEN3;
      endcase
    end
    else
    begin
      unique case (sel)
        2'h0: len = `IOBC_SIMPLE_LEN0;
        2'h1: len = `IOBC_SIMPLE_LEN1;
        2'h2: len = `IOBC_SIMPLE_LEN2;
        2'h3: len = `IOBC_SIMPLE_LEN3;
      endcase
    end
    return len;
  endfunction : strobe_len

  logic [7:0] div_cnt;
  logic tick16;
  logic tick8;
  logic slow_phase;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      div_cnt <= 8'h00;
      tick16 <= 1'b0;
      tick8 <= 1'b0;
      slow_phase <= 1'b0;
    end
    else if (div_cnt == 8'(FAST_DIV - 1))
    begin
      div_cnt <= 8'h00;
      tick16 <= 1'b1;
      tick8 <= slow_phase;
      slow_phase <= ~slow_phase;
    end
    else
    begin
      div_cnt <= div_cnt + 8'h01;
      tick16 <= 1'b0;
      tick8 <= 1'b0;
    end
  end

  // Square 8MHz clock on the pin; phases match tick8
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      slow_io_clock_out <= 1'b0;
    else
      slow_io_clock_out <= slow_phase;
  end

  // ****************************************************************
  // Request decode and cycle sequencing
  // ****************************************************************
  iobc_state_t state;
  iobc_state_t next_state;
  iobc_kind_t kind;
  logic [3:0] len_cnt;
  logic wr;
  logic [2:0] area;
  logic [31:0] wdata;
  logic [15:0] lo_data;
  logic [15:0] hi_data;
  logic hi_from_bus;
  logic tk;

  iobc_kind_t req_kind;
  logic [2:0] req_area;
  logic [1:0] req_type;

  always_comb
  begin
    req_kind = iobc_kind_t'(req_addr_in[`IOBC_KIND_HI:`IOBC_KIND_LO]);
    req_area = req_addr_in[`IOBC_AREA_HI:`IOBC_AREA_LO];
    req_type = req_addr_in[`IOBC_PCTYPE_HI:`IOBC_PCTYPE_LO];
    // Largest area is limited to the two shortest types
    if (req_area == `IOBC_LARGE_AREA)
      req_type[1] = 1'b0;
  end

  // Module and simple cycles step on 8MHz, PC cycles on 16MHz
  assign tk = (kind == IOBC_KIND_PC) ? tick16 : tick8;

  always_comb
  begin
    next_state = state;
    unique case (state)
      IOBC_ST_IDLE:
        if (req_valid_in && req_ready_out && req_kind != IOBC_KIND_NONE
            && !(req_kind == IOBC_KIND_PC
                 && req_area >= 3'(`IOBC_PC_AREAS)))
          next_state = IOBC_ST_SETUP;
      IOBC_ST_SETUP:
        if (tk)
          next_state = (kind == IOBC_KIND_MODULE) ? IOBC_ST_MWAIT : IOBC_ST_STROBE;
      IOBC_ST_STROBE:
        // Ready low at the last tick keeps the strobe asserted
        if (tk && len_cnt <= 4'h1 && (kind != IOBC_KIND_PC || ready_in))
          next_state = IOBC_ST_HOLD;
      IOBC_ST_MWAIT:
        if (tk && !module_grant_n_in)
          next_state = IOBC_ST_MREL;
      IOBC_ST_MREL:
        if (tk && module_grant_n_in)
          next_state = IOBC_ST_HOLD;
      IOBC_ST_HOLD:
        if (tk)
          next_state = IOBC_ST_DONE;
      IOBC_ST_DONE:
        next_state = IOBC_ST_IDLE;
      default:
        next_state = IOBC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      state <= IOBC_ST_IDLE;
    else
      state <= next_state;
  end

  // Captured request
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      kind <= IOBC_KIND_NONE;
      wr <= 1'b0;
      area <= 3'h0;
      wdata <= 32'h0000_0000;
      io_addr_out <= 16'h0000;
      len_cnt <= 4'h0;
    end
    else if (state == IOBC_ST_IDLE && next_state == IOBC_ST_SETUP)
    begin
      kind <= req_kind;
      wr <= req_write_in;
      area <= req_area;
      wdata <= req_wdata_in;
      io_addr_out <= req_addr_in[15:0];
      // Speed of a simple cycle comes from the address
      len_cnt <= strobe_len(req_kind, (req_kind == IOBC_KIND_PC) ? req_type
                            : req_addr_in[`IOBC_SPEED_HI:`IOBC_SPEED_LO]);
    end
    else if (state == IOBC_ST_STROBE && tk && len_cnt > 4'h1)
      len_cnt <= len_cnt - 4'h1;
  end

  // ****************************************************************
  // Pin control
  // ****************************************************************
  logic next_active;
  logic next_strobe;
  // Selects wait until kind and area are captured, so no stale select can glitch
  assign next_active = state != IOBC_ST_IDLE && next_state != IOBC_ST_IDLE
                       && next_state != IOBC_ST_DONE && next_state != IOBC_ST_HOLD;
  assign next_strobe = next_state == IOBC_ST_STROBE && kind != IOBC_KIND_MODULE;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      simple_cs_n_out <= 1'b1;
      module_cs_n_out <= 1'b1;
      pc_cs_n_out <= '1;
      io_read_strobe_n_out <= 1'b1;
      io_write_strobe_n_out <= 1'b1;
      module_request_n_out <= 1'b1;
      io_read_not_write_out <= 1'b1;
    end
    else
    begin
      simple_cs_n_out <= !(next_active && kind == IOBC_KIND_SIMPLE);
      module_cs_n_out <= !(next_active && kind == IOBC_KIND_MODULE);
      for (int i = 0; i < `IOBC_PC_AREAS; i++)
        pc_cs_n_out[i] <= !(next_active && kind == IOBC_KIND_PC && area == 3'(i));
      // Module cycles never use the strobes
      io_read_strobe_n_out <= !(next_strobe && !wr);
      io_write_strobe_n_out <= !(next_strobe && wr);
      module_request_n_out <= !(next_state == IOBC_ST_MWAIT);
      io_read_not_write_out <= (state == IOBC_ST_IDLE || next_state == IOBC_ST_IDLE) ? 1'b1
                               : !wr;
    end
  end

  // ****************************************************************
  // Data paths
  // ****************************************************************
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      io_data_out <= 16'h0000;
      io_data_oe_out <= 1'b0;
      ext_latch_out <= 1'b0;
      ext_dir_read_out <= 1'b0;
    end
    else
    begin
      // Simple and module writes carry the upper half; PC writes the lower
      io_data_out <= (kind == IOBC_KIND_PC) ? wdata[15:0] : wdata[31:16];
      // Data held through the hold phase for write hold margin
      io_data_oe_out <= wr && state != IOBC_ST_IDLE && next_state != IOBC_ST_IDLE
                        && next_state != IOBC_ST_DONE;
      // Extension latches carry the upper half unless it is multiplexed in
      ext_latch_out <= kind == IOBC_KIND_PC && !mux32_select_in
                       && (next_active || next_state == IOBC_ST_HOLD);
      ext_dir_read_out <= !wr;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      lo_data <= 16'h0000;
      hi_data <= 16'h0000;
      hi_from_bus <= 1'b0;
    end
    else if (state == IOBC_ST_IDLE)
      hi_from_bus <= 1'b0;
    else
    begin
      // Latching input marks the bus holding the upper half of a read
      if (kind == IOBC_KIND_PC && !wr && mux32_select_in && mux32_latch_in)
      begin
        hi_data <= io_data_in;
        hi_from_bus <= 1'b1;
      end
      if (state != next_state && (state == IOBC_ST_STROBE || state == IOBC_ST_MWAIT))
      begin
        lo_data <= io_data_in;
        if (!hi_from_bus)
          hi_data <= ext_hi_data_in;
      end
    end
  end

  // ****************************************************************
  // Processor answer
  // ****************************************************************
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      req_ready_out <= 1'b0;
      req_done_out <= 1'b0;
      req_rdata_out <= 32'h0000_0000;
    end
    else
    begin
      req_ready_out <= next_state == IOBC_ST_IDLE && state != IOBC_ST_IDLE
                       || state == IOBC_ST_IDLE && next_state == IOBC_ST_IDLE;
      req_done_out <= state == IOBC_ST_DONE;
      if (state == IOBC_ST_DONE && !wr)
        req_rdata_out <= (kind == IOBC_KIND_PC) ? {hi_data, lo_data}
                         : {16'h0000, lo_data};
    end
  end

endmodule : iobc_controller
`default_nettype wire

/* File: shared/iobc_cfg.svh */
// Purpose: Constants for the I/O bus cycle controller.
// Assumes: One system clock; all rates derived from it.
// Notes: Timing counts are derived from the rates below.
`ifndef IOBC_CFG_SVH
`define IOBC_CFG_SVH

// ****************************************************************
// Rates and dividers
// ****************************************************************
`define IOBC_SYS_HZ 100000000
`define IOBC_FAST_HZ 16000000
`define IOBC_SLOW_HZ 8000000
// Rounded down so the fast rate never runs slower than specified
`define IOBC_FAST_DIV (`IOBC_SYS_HZ / `IOBC_FAST_HZ)

// ****************************************************************
// Processor address decode
// ****************************************************************
`define IOBC_ADDR_W 24
`define IOBC_KIND_HI 23
`define IOBC_KIND_LO 22
`define IOBC_SPEED_HI 21
`define IOBC_SPEED_LO 20
`define IOBC_AREA_HI 21
`define IOBC_AREA_LO 19
`define IOBC_PCTYPE_HI 18
`define IOBC_PCTYPE_LO 17
`define IOBC_PC_AREAS 5
`define IOBC_LARGE_AREA 3'h4

// ****************************************************************
// Strobe lengths in ticks of the cycle's own rate
// ****************************************************************
`define IOBC_SIMPLE_LEN0 4'h1
`define IOBC_SIMPLE_LEN1 4'h2
`define IOBC_SIMPLE_LEN2 4'h3
`define IOBC_SIMPLE_LEN3 4'h4
`define IOBC_PC_LEN0 4'h2
`define IOBC_PC_LEN1 4'h3
`define IOBC_PC_LEN2 4'h4
`define IOBC_PC_LEN3 4'h6

`endif

/* File: shared/iobc_pkg.sv */
// Purpose: Types for the I/O bus cycle controller.
// Assumes: Included after iobc_cfg.svh constants are defined.
// Notes: States are Gray coded along the usual path from IDLE up to DONE.
package iobc_pkg;

  typedef enum logic [1:0]
  {
    IOBC_KIND_SIMPLE = 2'h0,
    IOBC_KIND_MODULE = 2'h1,
    IOBC_KIND_PC = 2'h2,
    IOBC_KIND_NONE = 2'h3
  } iobc_kind_t;

  typedef enum logic [2:0]
  {
    IOBC_ST_IDLE = 3'h0,
    IOBC_ST_SETUP = 3'h1,
    IOBC_ST_STROBE = 3'h3,
    IOBC_ST_HOLD = 3'h2,
    IOBC_ST_DONE = 3'h6,
    IOBC_ST_MWAIT = 3'h5,
    IOBC_ST_MREL = 3'h7
  } iobc_state_t;

endpackage : iobc_pkg

/* File: dv/iobc_checker.sv */
// Purpose: Port-level timing checks of the I/O bus cycle controller.
// Assumes: Bound into iobc_controller; one clock domain.
// Notes: Bounds scale with FAST_DIV so a shortened run stays valid.
`timescale 1ns/1ps
`default_nettype none
module iobc_checker
#(
  parameter int FAST_DIV = 6
)
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire logic [23:0] req_addr_in,
  input wire logic req_ready_out,
  input wire logic req_done_out,
  input wire logic io_data_oe_out,
  input wire logic io_read_strobe_n_out,
  input wire logic io_write_strobe_n_out,
  input wire logic io_read_not_write_out,
  input wire logic simple_cs_n_out,
  input wire logic module_cs_n_out,
  input wire logic [4:0] pc_cs_n_out,
  input wire logic module_request_n_out,
  input wire logic module_grant_n_in,
  input wire logic ready_in
);
  // ********************************
  // Checks
  // ********************************
  localparam int SEL_MAX = 8 * FAST_DIV;
  localparam int REL_MAX = 4 * FAST_DIV;
  logic taken;
  logic strobe;
  logic pc_sel;
  assign pc_sel = pc_cs_n_out != 5'h1f;
  assign strobe = !io_read_strobe_n_out || !io_write_strobe_n_out;
  // Unmapped kinds and areas above 4 are refused, so they must not count as taken
  assign taken = req_valid_in && req_ready_out && req_addr_in[23:22] != 2'h3
    && !(req_addr_in[23:22] == 2'h2 && req_addr_in[21:19] > 3'h4);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  a_take_busy: assert property (taken |=> !req_ready_out)
    else $error("ready stayed high after a request was taken");
  a_take_select: assert property (taken |-> ##[1:SEL_MAX] (!simple_cs_n_out
    || !module_cs_n_out || pc_sel))
    else $error("no chip select followed a taken request");
  a_done_once: assert property (req_done_out |=> !req_done_out && req_ready_out)
    else $error("done not a single pulse followed by ready");
  a_module_quiet: assert property (!module_cs_n_out |-> !strobe)
    else $error("strobe active during a module cycle");
  a_strobe_select: assert property (strobe |-> module_cs_n_out
    && (!simple_cs_n_out || pc_sel))
    else $error("strobe without a simple or area select");
  a_pc_single: assert property ($onehot0(~pc_cs_n_out))
    else $error("more than one area select active");
  a_write_dir: assert property (!io_write_strobe_n_out |-> !io_read_not_write_out
    && io_data_oe_out && io_read_strobe_n_out)
    else $error("write strobe with wrong direction or data not driven");
  a_read_dir: assert property (!io_read_strobe_n_out |-> io_read_not_write_out
    && !io_data_oe_out)
    else $error("read strobe with wrong direction or data driven");
  a_request_select: assert property (!module_request_n_out |-> !module_cs_n_out)
    else $error("module request without module select");
  a_grant_release: assert property (!module_grant_n_in && !module_request_n_out
    |-> ##[1:REL_MAX] module_request_n_out)
    else $error("module request not released after grant");
  a_stretch_hold: assert property (!ready_in && pc_sel && strobe |=> strobe)
    else $error("area strobe ended while ready was low");
  cover property (!module_request_n_out && !module_grant_n_in);
  cover property (!ready_in && pc_sel && strobe);
  cover property (req_done_out && io_read_not_write_out);
endmodule : iobc_checker
bind iobc_controller iobc_checker #(.FAST_DIV(FAST_DIV)) u_chk
(
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
  .req_addr_in(req_addr_in), .req_ready_out(req_ready_out), .req_done_out(req_done_out),
  .io_data_oe_out(io_data_oe_out), .io_read_strobe_n_out(io_read_strobe_n_out),
  .io_write_strobe_n_out(io_write_strobe_n_out),
  .io_read_not_write_out(io_read_not_write_out), .simple_cs_n_out(simple_cs_n_out),
  .module_cs_n_out(module_cs_n_out), .pc_cs_n_out(pc_cs_n_out),
  .module_request_n_out(module_request_n_out), .module_grant_n_in(module_grant_n_in),
  .ready_in(ready_in)
);
`default_nettype wire

/* File: dv/iobc_partner.sv */
// Purpose: Behavioural peripherals on the far side of the I/O bus.
// Assumes: Reply values and delays are set by the bench.
// Notes: Grant and ready may answer promptly or slowly.
`timescale 1ns/1ps
`default_nettype none
module iobc_partner
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic io_read_strobe_n_in,
  input wire logic io_write_strobe_n_in,
  input wire logic io_read_not_write_in,
  input wire logic module_cs_n_in,
  input wire logic module_request_n_in,
  input wire logic ext_latch_in,
  input wire logic [15:0] rd_val_in,
  input wire logic [15:0] hi_val_in,
  input wire logic [7:0] stall_in,
  input wire logic [7:0] grant_wait_in,
  output logic [15:0] io_data_out,
  output logic [15:0] ext_hi_data_out,
  output logic module_grant_n_out,
  output logic ready_out
);
  // ********************************
  // Replies
  // ********************************
  logic [7:0] cnt;
  logic strobe;
  logic drive;
  assign strobe = !io_read_strobe_n_in || !io_write_strobe_n_in;
  assign drive = !io_read_strobe_n_in || (!module_cs_n_in && io_read_not_write_in);
  // Released lines show the inverse so stale data can never pass for a reply
  assign io_data_out = drive ? rd_val_in : ~rd_val_in;
  assign ext_hi_data_out = ext_latch_in ? hi_val_in : ~hi_val_in;
  assign ready_out = !(strobe && cnt < stall_in);
  assign module_grant_n_out = !(!module_request_n_in && cnt >= grant_wait_in);
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in || !(strobe || !module_request_n_in))
    begin
      cnt <= 8'h0;
    end
    else if (cnt != 8'hff)
    begin
      cnt <= cnt + 8'h1;
    end
  end
endmodule : iobc_partner
`default_nettype wire

/* File: dv/testbench.sv */
// Purpose: Self-checking bench for the I/O bus cycle controller.
// Assumes: FAST_DIV cut to 2; peripherals modelled by iobc_partner.
// Notes: Inputs change 1ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "iobc_cfg.svh"
module testbench;
  // ********************************
  // Bench
  // ********************************
  localparam int FD = 2;
  logic clk, rst_n, valid, write, oe, rd_n, wr_n, rnw, scs_n, mcs_n, mreq_n, gnt_n, rdy;
  logic latch, msel, mlat, ready, done, sclk, edir;
  logic [23:0] addr;
  logic [31:0] wdata, rdata;
  logic [15:0] ido, idi, ehi, rv, hv, wseen, ioa;
  logic [4:0] pcs_n;
  logic [7:0] stall, gw;
  logic [6:0] csl;
  int dur, compares, num_errors;
  logic [3:0] slen [4] = '{`IOBC_SIMPLE_LEN0, `IOBC_SIMPLE_LEN1, `IOBC_SIMPLE_LEN2,
    `IOBC_SIMPLE_LEN3};
  logic [3:0] plen [4] = '{`IOBC_PC_LEN0, `IOBC_PC_LEN1, `IOBC_PC_LEN2, `IOBC_PC_LEN3};
  iobc_controller #(.FAST_DIV(FD)) dut
  (
    .clk_sys_in(clk), .rst_n_in(rst_n), .req_valid_in(valid), .req_write_in(write),
    .req_addr_in(addr), .req_wdata_in(wdata), .req_ready_out(ready), .req_done_out(done),
    .req_rdata_out(rdata), .io_addr_out(ioa), .io_data_out(ido), .io_data_oe_out(oe),
    .io_data_in(idi), .io_read_strobe_n_out(rd_n), .io_write_strobe_n_out(wr_n),
    .io_read_not_write_out(rnw), .simple_cs_n_out(scs_n), .module_cs_n_out(mcs_n),
    .pc_cs_n_out(pcs_n), .module_request_n_out(mreq_n), .module_grant_n_in(gnt_n),
    .ready_in(rdy), .slow_io_clock_out(sclk), .ext_latch_out(latch), .ext_dir_read_out(edir),
    .ext_hi_data_in(ehi), .mux32_select_in(msel), .mux32_latch_in(mlat)
  );
  iobc_partner peer
  (
    .clk_sys_in(clk), .rst_n_in(rst_n), .io_read_strobe_n_in(rd_n), .io_write_strobe_n_in(wr_n),
    .io_read_not_write_in(rnw), .module_cs_n_in(mcs_n), .module_request_n_in(mreq_n),
    .ext_latch_in(latch), .rd_val_in(rv), .hi_val_in(hv), .stall_in(stall), .grant_wait_in(gw),
    .io_data_out(idi), .ext_hi_data_out(ehi), .module_grant_n_out(gnt_n), .ready_out(rdy)
  );
  always #5 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [23:0] adr(input logic [1:0] k, input logic [2:0] f,
    input logic [1:0] t);
    return {k, f, t, 1'b0, 16'h0c40};
  endfunction : adr
  // One access; records strobe length, selects seen and data driven
  task automatic acc(input logic w, input logic [23:0] a, input logic [31:0] d);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    valid = 1'b1;
    write = w;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
    valid = 1'b0;
    dur = 0;
    csl = 7'h0;
    n = 0;
    while (done !== 1'b1 && n < 400)
    begin
      dur += (rd_n === 1'b0 || wr_n === 1'b0);
      csl |= ~{scs_n, mcs_n, pcs_n};
      if (wr_n === 1'b0 || (mcs_n === 1'b0 && rnw === 1'b0))
        wseen = ido;
      @(posedge clk);
      #1;
      n++;
    end
    chk({31'h0, done}, 32'h1);
    // Next request only in the cycle after done
    @(posedge clk);
    #1;
  endtask : acc
  task automatic t_simple();
    logic sc;
    sc = sclk;
    repeat (FD) @(posedge clk);
    #1;
    chk({31'h0, sclk ^ sc}, 32'h1);
    for (int s = 0; s < 4; s++)
    begin
      rv = 16'ha5c0 + 16'(s);
      acc(1'b0, adr(2'h0, {s[1:0], 1'b0}, 2'h0), 32'h0);
      chk({16'h0, ioa}, 32'h0c40);
      chk(dur, 2 * FD * slen[s]);
      chk({25'h0, csl}, 32'h40);
      chk(rdata, {16'h0, rv});
      acc(1'b1, adr(2'h0, {s[1:0], 1'b0}, 2'h0), {16'hc3d0 + 16'(s), 16'h1111});
      chk({16'h0, wseen}, 32'hc3d0 + s);
      chk(rdata, {16'h0, rv});
    end
  endtask : t_simple
  task automatic t_module();
    for (int i = 0; i < 2; i++)
    begin
      gw = i ? 8'hc : 8'h1;
      rv = 16'h5a00 + 16'(i);
      acc(1'b0, adr(2'h1, 3'h0, 2'h0), 32'h0);
      chk(dur, 0);
      chk({25'h0, csl}, 32'h20);
      chk(rdata, {16'h0, rv});
      acc(1'b1, adr(2'h1, 3'h0, 2'h0), {16'h6b00 + 16'(i), 16'h2222});
      chk({16'h0, wseen}, 32'h6b00 + i);
      chk(dur, 0);
    end
  endtask : t_module
  task automatic t_pc();
    logic [1:0] tt;
    logic [15:0] wl;
    for (int a = 0; a < 5; a++)
    begin
      for (int t = 0; t < 4; t++)
      begin
        tt = (a == 4) ? {1'b0, t[0]} : t[1:0];
        rv = 16'h4b00 + 16'(a);
        wl = 16'h3c00 + 16'(4 * a + t);
        acc(t[0], adr(2'h2, a[2:0], t[1:0]), {16'h7e00, wl});
        chk(dur, FD * plen[tt]);
        chk({25'h0, csl}, 32'h1 << a);
        if (t[0])
          chk({16'h0, wseen}, {16'h0, wl});
        else
          chk(rdata, {hv, rv});
        chk({31'h0, edir}, {31'h0, !t[0]});
      end
    end
  endtask : t_pc
  task automatic t_stall();
    stall = 8'd20;
    acc(1'b0, adr(2'h2, 3'h2, 2'h0), 32'h0);
    chk({31'h0, dur >= 20 && dur <= 20 + 2 * FD}, 32'h1);
    stall = 8'h0;
  endtask : t_stall
  task automatic t_mux32();
    msel = 1'b1;
    fork
      acc(1'b0, adr(2'h2, 3'h1, 2'h0), 32'h0);
      begin
        @(negedge rd_n);
        #1;
        rv = 16'hd00d;
        mlat = 1'b1;
        @(posedge clk);
        #1;
        mlat = 1'b0;
        rv = 16'h0bee;
      end
    join
    chk(rdata, 32'hd00d0bee);
    msel = 1'b0;
  endtask : t_mux32
  task automatic t_refused();
    int bad;
    logic [23:0] bad_addr [2];
    bad = 0;
    bad_addr = '{adr(2'h3, 3'h0, 2'h0), adr(2'h2, 3'h5, 2'h0)};
    valid = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      addr = bad_addr[i];
      repeat (12)
      begin
        @(posedge clk);
        #1;
        bad += (ready !== 1'b1 || done !== 1'b0 || pcs_n !== 5'h1f);
      end
    end
    valid = 1'b0;
    chk(bad, 0);
  endtask : t_refused
  task automatic report_and_stop();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {valid, write, msel, mlat} = 4'h0;
    addr = 24'h0;
    wdata = 32'h0;
    {rv, hv, stall, gw} = {16'h0, 16'h9e1f, 8'h0, 8'h1};
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({21'h0, rd_n, wr_n, scs_n, mcs_n, pcs_n, mreq_n, ready}, 32'h7ff);
    t_simple();
    t_module();
    t_pc();
    t_stall();
    t_mux32();
    t_refused();
    report_and_stop();
  end
  initial
  begin
    #100000;
    num_errors++;
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
